//--- core/mpf_port_top.sv
// Port and pin-function logic with an APB register file.
// Assumes pads resolve each pin from out and oe, and peripherals share pclk.
//
// What this block does
// - Each of the eight bit-port pins has its own open-drain latch and reads input while it holds one.
// - Both key nibble ports act as four-bit open-drain ports that read input when the latch is one.
// - Every key port pin has a pull-up and a key-on wakeup, each switched by a software bit.
// - The interrupt nibble port is open-drain and its two lowest pins feed the two external interrupts.
// - The analog nibble port is open-drain and its pins double as the upper four analog inputs.
// - The push-pull nibble port has a direction bit per pin, zero for input and one for output.
// - Timer pin A feeds the second timer count input and can drive the first timer underflow halved.
// - Timer pin B feeds the fourth timer count input and can drive the third timer underflow halved.
// - The reset pin is open-drain and is pulled low when the watchdog or drop detector resets.
// - The external interrupt pins raise requests and also wake the system from RAM back-up.
// - The three shared input pins carry serial clock, serial data out and serial data in in that order.
// - The lower analog inputs go to two comparators only while software selects the comparator.
// - The serial clock pin is input or output and the data pins shift data under software control.
// - After reset all push-pull direction bits are zero so the port starts as input.
// - Port input reads of shared pins work while any alternate function is selected.
`timescale 1ns/1ps
module mpf_port_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] bit_port_pins_in,
	output logic [7:0] bit_port_pins_out,
	output logic [7:0] bit_port_pins_oe,
	input wire logic [3:0] key_port_a_pins_in,
	output logic [3:0] key_port_a_pins_out,
	output logic [3:0] key_port_a_pins_oe,
	output logic [3:0] key_port_a_pullup_en,
	input wire logic [3:0] key_port_b_pins_in,
	output logic [3:0] key_port_b_pins_out,
	output logic [3:0] key_port_b_pins_oe,
	output logic [3:0] key_port_b_pullup_en,
	input wire logic [2:0] serial_shared_input_pins_in,
	output logic serial_clk_pin_out,
	output logic serial_clk_pin_oe,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	input wire logic [3:0] interrupt_shared_port_pins_in,
	output logic [3:0] interrupt_shared_port_pins_out,
	output logic [3:0] interrupt_shared_port_pins_oe,
	input wire logic [3:0] analog_shared_port_pins_in,
	output logic [3:0] analog_shared_port_pins_out,
	output logic [3:0] analog_shared_port_pins_oe,
	input wire logic [3:0] push_pull_port_pins_in,
	output logic [3:0] push_pull_port_pins_out,
	output logic [3:0] push_pull_port_pins_oe,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic reset_pin_level,
	input wire logic drop_detector_enable_pin,
	output logic drop_detector_run,
	input wire logic timer1_underflow,
	input wire logic timer3_underflow,
	output logic timer2_count_in,
	output logic timer4_count_in,
	input wire logic sio_clk_out,
	input wire logic sio_data_out,
	output logic sio_clk_in,
	output logic sio_data_in,
	output logic ext_irq_a,
	output logic ext_irq_b,
	output logic comparator_select,
	input wire logic wdt_reset_req,
	input wire logic vdd_reset_req,
	input wire logic ram_backup,
	output logic wake_request,
	output logic irq
);

	mpf_pkg::mpf_state_t state_reg;
	mpf_pkg::mpf_state_t state_next;
	mpf_pkg::mpf_pin_in_t raw_in;
	mpf_pkg::mpf_pin_in_t pin;

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic logic addr_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a == mpf_pkg::OFF_BIT_OUT) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_KEY_OUT) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_IRQP_OUT) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_ANA_OUT) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_PP_OUT) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_PP_DIR) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_PULL_EN) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_WAKE_EN) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_FUNC) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_BIT_IN) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_KEY_IN) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_MISC_IN) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_ANPP_IN) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_STATUS) begin
			hit = 1'b1;
		end else if (a == mpf_pkg::OFF_MASK) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// An open-drain pin drives only its low level, so the enable is the inverted latch.
	function automatic logic [7:0] od_enable(input logic [7:0] latch);
		return ~latch;
	endfunction

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	always_comb begin
		raw_in.rst = reset_pin_in;
		raw_in.dde = drop_detector_enable_pin;
		raw_in.push_pull = push_pull_port_pins_in;
		raw_in.analog = analog_shared_port_pins_in;
		raw_in.irqp = interrupt_shared_port_pins_in;
		raw_in.serial = serial_shared_input_pins_in;
		raw_in.key_b = key_port_b_pins_in;
		raw_in.key_a = key_port_a_pins_in;
		raw_in.bits = bit_port_pins_in;
	end

	mpf_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(raw_in),
		.stable_out(pin)
	);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	logic setup_ph;
	logic access_ph;
	logic [3:0] events;
	logic [7:0] key_low;
	logic [7:0] key_latch;

	always_comb begin
		setup_ph = psel & ~penable;
		access_ph = psel & penable;
		state_next = state_reg;

		// Timer toggles divide the underflow pulses by two.
		state_next.tog_a = state_reg.tog_a ^ timer1_underflow;
		state_next.tog_b = state_reg.tog_b ^ timer3_underflow;

		// Serial output data is retimed so the pin never sees a peripheral glitch.
		state_next.sck_o = sio_clk_out;
		state_next.sdo_o = sio_data_out;

		// Either system-reset source pulls the reset pin low.
		state_next.rst_drive = wdt_reset_req | vdd_reset_req;

		// Key wake needs the latch at one, since a pin held low by its own latch is no key.
		key_latch = state_reg.key_out;
		key_low = ~{pin.key_b, pin.key_a} & key_latch & state_reg.wake_en;

		events = '0;
		events[mpf_pkg::ST_IRQ_A] = pin.irqp[0] & ~state_reg.prev_irq[0];
		events[mpf_pkg::ST_IRQ_B] = pin.irqp[1] & ~state_reg.prev_irq[1];
		events[mpf_pkg::ST_KEY] = |key_low;
		state_next.prev_irq = pin.irqp[1:0];

		// Wake from back-up on an interrupt edge or a pressed key.
		state_next.wake_req = ram_backup & (|events);

		// Read data is captured in the setup cycle so prdata comes from a flip-flop.
		if (setup_ph && !pwrite) begin
			state_next.prdata = '0;
			if (paddr == mpf_pkg::OFF_BIT_OUT) begin
				state_next.prdata[7:0] = state_reg.bit_out;
			end else if (paddr == mpf_pkg::OFF_KEY_OUT) begin
				state_next.prdata[7:0] = state_reg.key_out;
			end else if (paddr == mpf_pkg::OFF_IRQP_OUT) begin
				state_next.prdata[3:0] = state_reg.irqp_out;
			end else if (paddr == mpf_pkg::OFF_ANA_OUT) begin
				state_next.prdata[3:0] = state_reg.ana_out;
			end else if (paddr == mpf_pkg::OFF_PP_OUT) begin
				state_next.prdata[3:0] = state_reg.pp_out;
			end else if (paddr == mpf_pkg::OFF_PP_DIR) begin
				state_next.prdata[3:0] = state_reg.pp_dir;
			end else if (paddr == mpf_pkg::OFF_PULL_EN) begin
				state_next.prdata[7:0] = state_reg.pull_en;
			end else if (paddr == mpf_pkg::OFF_WAKE_EN) begin
				state_next.prdata[7:0] = state_reg.wake_en;
			end else if (paddr == mpf_pkg::OFF_FUNC) begin
				state_next.prdata[7:0] = state_reg.func;
			end else if (paddr == mpf_pkg::OFF_BIT_IN) begin
				state_next.prdata[7:0] = pin.bits;
			end else if (paddr == mpf_pkg::OFF_KEY_IN) begin
				state_next.prdata[7:0] = {pin.key_b, pin.key_a};
			end else if (paddr == mpf_pkg::OFF_MISC_IN) begin
				state_next.prdata[7:0] = {pin.irqp, 1'b0, pin.serial};
			end else if (paddr == mpf_pkg::OFF_ANPP_IN) begin
				state_next.prdata[7:0] = {pin.push_pull, pin.analog};
			end else if (paddr == mpf_pkg::OFF_STATUS) begin
				state_next.prdata[3:0] = state_reg.status;
			end else if (paddr == mpf_pkg::OFF_MASK) begin
				state_next.prdata[3:0] = state_reg.mask;
			end
		end

		// A read clears only the bits it returned, and a new event in that cycle still sets.
		if (access_ph && !pwrite && paddr == mpf_pkg::OFF_STATUS) begin
			state_next.status = (state_reg.status & ~state_reg.prdata[3:0]) | events;
		end else begin
			state_next.status = state_reg.status | events;
		end

		if (access_ph && pwrite) begin
			if (paddr == mpf_pkg::OFF_BIT_OUT) begin
				state_next.bit_out = pwdata[7:0];
			end else if (paddr == mpf_pkg::OFF_KEY_OUT) begin
				state_next.key_out = pwdata[7:0];
			end else if (paddr == mpf_pkg::OFF_IRQP_OUT) begin
				state_next.irqp_out = pwdata[3:0];
			end else if (paddr == mpf_pkg::OFF_ANA_OUT) begin
				state_next.ana_out = pwdata[3:0];
			end else if (paddr == mpf_pkg::OFF_PP_OUT) begin
				state_next.pp_out = pwdata[3:0];
			end else if (paddr == mpf_pkg::OFF_PP_DIR) begin
				state_next.pp_dir = pwdata[3:0];
			end else if (paddr == mpf_pkg::OFF_PULL_EN) begin
				state_next.pull_en = pwdata[7:0];
			end else if (paddr == mpf_pkg::OFF_WAKE_EN) begin
				state_next.wake_en = pwdata[7:0];
			end else if (paddr == mpf_pkg::OFF_FUNC) begin
				state_next.func = pwdata[7:0];
			end else if (paddr == mpf_pkg::OFF_MASK) begin
				state_next.mask = pwdata[3:0];
			end
		end

		state_next.irq = |(state_next.status & state_next.mask);
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.bit_out <= mpf_pkg::RST_LATCH8;
			state_reg.key_out <= mpf_pkg::RST_LATCH8;
			state_reg.irqp_out <= mpf_pkg::RST_LATCH4;
			state_reg.ana_out <= mpf_pkg::RST_LATCH4;
			state_reg.pp_out <= mpf_pkg::RST_DIR;
			state_reg.pp_dir <= mpf_pkg::RST_DIR;
			state_reg.pull_en <= mpf_pkg::RST_EN8;
			state_reg.wake_en <= mpf_pkg::RST_EN8;
			state_reg.func <= mpf_pkg::RST_EN8;
			state_reg.status <= mpf_pkg::RST_ST;
			state_reg.mask <= mpf_pkg::RST_ST;
			state_reg.prdata <= '0;
			state_reg.tog_a <= 1'b0;
			state_reg.tog_b <= 1'b0;
			state_reg.prev_irq <= '0;
			state_reg.sck_o <= 1'b0;
			state_reg.sdo_o <= 1'b0;
			state_reg.rst_drive <= 1'b0;
			state_reg.wake_req <= 1'b0;
			state_reg.irq <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Pin and peripheral outputs
	// ************************************************************
	logic [7:0] bit_eff;

	always_comb begin
		bit_eff = state_reg.bit_out;
		// The timer output ANDs with the latch, so a zero latch still holds the pin low.
		if (state_reg.func[mpf_pkg::FS_TMR_A_OUT]) begin
			bit_eff[mpf_pkg::BIT_TMR_A] = state_reg.bit_out[mpf_pkg::BIT_TMR_A] & state_reg.tog_a;
		end
		if (state_reg.func[mpf_pkg::FS_TMR_B_OUT]) begin
			bit_eff[mpf_pkg::BIT_TMR_B] = state_reg.bit_out[mpf_pkg::BIT_TMR_B] & state_reg.tog_b;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~addr_mapped(paddr);

	assign bit_port_pins_out = '0;
	assign bit_port_pins_oe = od_enable(bit_eff);
	assign key_port_a_pins_out = '0;
	assign key_port_a_pins_oe = ~state_reg.key_out[3:0];
	assign key_port_a_pullup_en = state_reg.pull_en[3:0];
	assign key_port_b_pins_out = '0;
	assign key_port_b_pins_oe = ~state_reg.key_out[7:4];
	assign key_port_b_pullup_en = state_reg.pull_en[7:4];
	assign interrupt_shared_port_pins_out = '0;
	assign interrupt_shared_port_pins_oe = ~state_reg.irqp_out;
	assign analog_shared_port_pins_out = '0;
	assign analog_shared_port_pins_oe = ~state_reg.ana_out;
	assign push_pull_port_pins_out = state_reg.pp_out;
	assign push_pull_port_pins_oe = state_reg.pp_dir;

	assign serial_clk_pin_out = state_reg.sck_o;
	assign serial_clk_pin_oe = state_reg.func[mpf_pkg::FS_SCK_OUT];
	assign serial_data_pin_out = state_reg.sdo_o;
	assign serial_data_pin_oe = state_reg.func[mpf_pkg::FS_SDO_OUT];
	assign sio_clk_in = pin.serial[mpf_pkg::SER_CLK];
	assign sio_data_in = pin.serial[mpf_pkg::SER_DI];

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = state_reg.rst_drive;
	assign reset_pin_level = pin.rst;
	assign drop_detector_run = pin.dde;

	assign timer2_count_in = pin.bits[mpf_pkg::BIT_TMR_A];
	assign timer4_count_in = pin.bits[mpf_pkg::BIT_TMR_B];
	assign ext_irq_a = pin.irqp[0];
	assign ext_irq_b = pin.irqp[1];
	assign comparator_select = state_reg.func[mpf_pkg::FS_CMP_SEL];
	assign wake_request = state_reg.wake_req;
	assign irq = state_reg.irq;

endmodule

//--- core/mpf_pkg.sv
// Constants, register map and packed carriers for the port and pin-function block.
// Assumes a single pclk domain and an APB master with 32-bit data.
package mpf_pkg;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFF_BIT_OUT = 8'h00;
	localparam logic [7:0] OFF_KEY_OUT = 8'h04;
	localparam logic [7:0] OFF_IRQP_OUT = 8'h08;
	localparam logic [7:0] OFF_ANA_OUT = 8'h0c;
	localparam logic [7:0] OFF_PP_OUT = 8'h10;
	localparam logic [7:0] OFF_PP_DIR = 8'h14;
	localparam logic [7:0] OFF_PULL_EN = 8'h18;
	localparam logic [7:0] OFF_WAKE_EN = 8'h1c;
	localparam logic [7:0] OFF_FUNC = 8'h20;
	localparam logic [7:0] OFF_BIT_IN = 8'h24;
	localparam logic [7:0] OFF_KEY_IN = 8'h28;
	localparam logic [7:0] OFF_MISC_IN = 8'h2c;
	localparam logic [7:0] OFF_ANPP_IN = 8'h30;
	localparam logic [7:0] OFF_STATUS = 8'h34;
	localparam logic [7:0] OFF_MASK = 8'h38;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] RST_LATCH8 = 8'hff;
	localparam logic [3:0] RST_LATCH4 = 4'hf;
	localparam logic [3:0] RST_DIR = 4'h0;
	localparam logic [7:0] RST_EN8 = 8'h00;
	localparam logic [3:0] RST_ST = 4'h0;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int FS_TMR_A_OUT = 0;
	localparam int FS_TMR_B_OUT = 1;
	localparam int FS_CMP_SEL = 2;
	localparam int FS_SCK_OUT = 3;
	localparam int FS_SDO_OUT = 4;
	localparam int BIT_TMR_A = 6;
	localparam int BIT_TMR_B = 7;
	localparam int ST_IRQ_A = 0;
	localparam int ST_IRQ_B = 1;
	localparam int ST_KEY = 2;
	localparam int SER_CLK = 0;
	localparam int SER_DO = 1;
	localparam int SER_DI = 2;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic rst;
		logic dde;
		logic [3:0] push_pull;
		logic [3:0] analog;
		logic [3:0] irqp;
		logic [2:0] serial;
		logic [3:0] key_b;
		logic [3:0] key_a;
		logic [7:0] bits;
	} mpf_pin_in_t;

	typedef struct packed {
		mpf_pin_in_t s1;
		mpf_pin_in_t s2;
		mpf_pin_in_t s3;
		mpf_pin_in_t stable;
	} mpf_sync_t;

	typedef struct packed {
		logic [7:0] bit_out;
		logic [7:0] key_out;
		logic [3:0] irqp_out;
		logic [3:0] ana_out;
		logic [3:0] pp_out;
		logic [3:0] pp_dir;
		logic [7:0] pull_en;
		logic [7:0] wake_en;
		logic [7:0] func;
		logic [3:0] status;
		logic [3:0] mask;
		logic [31:0] prdata;
		logic tog_a;
		logic tog_b;
		logic [1:0] prev_irq;
		logic sck_o;
		logic sdo_o;
		logic rst_drive;
		logic wake_req;
		logic irq;
	} mpf_state_t;

endpackage

//--- core/mpf_sync.sv
// Three-stage synchroniser for every pin input of the port block.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
module mpf_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire mpf_pkg::mpf_pin_in_t async_in,
	output mpf_pkg::mpf_pin_in_t stable_out
);

	mpf_pkg::mpf_sync_t state_reg;
	mpf_pkg::mpf_sync_t state_next;

	// ************************************************************
	// Filter
	// ************************************************************
	// A bit moves only when stages two and three agree, which rejects one-cycle glitches.
	always_comb begin
		state_next = state_reg;
		state_next.s1 = async_in;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		state_next.stable = (state_reg.s2 & state_reg.s3) |
			(state_reg.stable & (state_reg.s2 | state_reg.s3));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign stable_out = state_reg.stable;

endmodule

//--- test/mpf_port_assertions.sv
// Checker for the port block; it watches only ports of mpf_port_top.
// Assumes one pclk domain.
`timescale 1ns/1ps
module mpf_port_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0] bit_port_pins_oe,
	input wire logic [3:0] key_port_a_pins_oe,
	input wire logic [3:0] key_port_b_pins_oe,
	input wire logic [3:0] key_port_a_pullup_en,
	input wire logic [3:0] key_port_b_pullup_en,
	input wire logic [3:0] interrupt_shared_port_pins_oe,
	input wire logic [3:0] analog_shared_port_pins_oe,
	input wire logic [3:0] push_pull_port_pins_oe,
	input wire logic reset_pin_oe,
	input wire logic wdt_reset_req,
	input wire logic vdd_reset_req,
	input wire logic comparator_select,
	input wire logic serial_clk_pin_oe,
	input wire logic ram_backup,
	input wire logic wake_request
);
	logic wr;
	assign wr = psel && penable && pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_bit_od; wr && paddr == mpf_pkg::OFF_BIT_OUT |=>
		bit_port_pins_oe[5:0] == ~$past(pwdata[5:0]); endproperty
	a_bit_od: assert property (p_bit_od) else $error("bit port drive wrong");
	property p_key_od; wr && paddr == mpf_pkg::OFF_KEY_OUT |=>
		{key_port_b_pins_oe, key_port_a_pins_oe} == ~$past(pwdata[7:0]); endproperty
	a_key_od: assert property (p_key_od) else $error("key port drive wrong");
	property p_pull; wr && paddr == mpf_pkg::OFF_PULL_EN |=>
		{key_port_b_pullup_en, key_port_a_pullup_en} == $past(pwdata[7:0]); endproperty
	a_pull: assert property (p_pull) else $error("pull-up enable wrong");
	property p_irqp_od; wr && paddr == mpf_pkg::OFF_IRQP_OUT |=>
		interrupt_shared_port_pins_oe == ~$past(pwdata[3:0]); endproperty
	a_irqp_od: assert property (p_irqp_od) else $error("irq port drive wrong");
	property p_ana_od; wr && paddr == mpf_pkg::OFF_ANA_OUT |=>
		analog_shared_port_pins_oe == ~$past(pwdata[3:0]); endproperty
	a_ana_od: assert property (p_ana_od) else $error("analog port drive wrong");
	property p_pp_dir; wr && paddr == mpf_pkg::OFF_PP_DIR |=>
		push_pull_port_pins_oe == $past(pwdata[3:0]); endproperty
	a_pp_dir: assert property (p_pp_dir) else $error("direction wrong");
	property p_rst_pin; wdt_reset_req || vdd_reset_req |=> reset_pin_oe; endproperty
	a_rst_pin: assert property (p_rst_pin) else $error("reset pin not pulled");
	property p_dir_rst; $rose(presetn) |-> push_pull_port_pins_oe == 4'h0; endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("port not input after reset");
	property p_func; wr && paddr == mpf_pkg::OFF_FUNC |=>
		{serial_clk_pin_oe, comparator_select} == $past(pwdata[3:2]); endproperty
	a_func: assert property (p_func) else $error("function select wrong");
	property p_wake; wake_request |-> $past(ram_backup); endproperty
	a_wake: assert property (p_wake) else $error("wake outside back-up");
endmodule

//--- test/mpf_board_model.sv
// Board model: resolves each shared pin from board drive and the block's enables.
// Assumes the board only pulls lines low; a released line rises by its pull-up.
`timescale 1ns/1ps
module mpf_board_model (
	input wire mpf_pkg::mpf_pin_in_t board,
	input wire logic [7:0] bit_oe,
	input wire logic [7:0] key_oe,
	input wire logic [3:0] irqp_oe,
	input wire logic [3:0] ana_oe,
	input wire logic [3:0] pp_out,
	input wire logic [3:0] pp_oe,
	input wire logic [1:0] ser_out,
	input wire logic [1:0] ser_oe,
	input wire logic rst_oe,
	output mpf_pkg::mpf_pin_in_t pins
);
	// An open-drain line is low where either side pulls it; push-pull and serial lines follow the block where it enables them.
	always_comb begin
		pins = board;
		pins.bits = board.bits & ~bit_oe;
		{pins.key_b, pins.key_a} = {board.key_b, board.key_a} & ~key_oe;
		pins.irqp = board.irqp & ~irqp_oe;
		pins.analog = board.analog & ~ana_oe;
		pins.rst = board.rst & ~rst_oe;
		pins.push_pull = (pp_out & pp_oe) | (board.push_pull & ~pp_oe);
		pins.serial[1:0] = (ser_out & ser_oe) | (board.serial[1:0] & ~ser_oe);
	end
endmodule

//--- test/test_mcu_port_pin_functions.sv
// Self-checking bench: APB master, board model and bound checker around mpf_port_top.
// Assumes the block answers APB in its access cycle and pin inputs settle in 4 edges.
`timescale 1ns/1ps
module test_mcu_port_pin_functions;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, bit_port_pins_oe;
	logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h40;
	logic timer1_underflow = 1'b0, timer3_underflow = 1'b0, sio_clk_out = 1'b0;
	logic sio_data_out = 1'b0, wdt_reset_req = 1'b0, vdd_reset_req = 1'b0, ram_backup = 1'b0;
	logic [3:0] key_port_a_pins_oe, key_port_b_pins_oe, key_port_a_pullup_en, key_port_b_pullup_en;
	logic [3:0] interrupt_shared_port_pins_oe, analog_shared_port_pins_oe;
	logic [3:0] push_pull_port_pins_out, push_pull_port_pins_oe;
	logic pready, pslverr, serial_clk_pin_out, serial_clk_pin_oe, serial_data_pin_out;
	logic serial_data_pin_oe, reset_pin_oe, reset_pin_level, drop_detector_run, irq;
	logic timer2_count_in, timer4_count_in, sio_clk_in, sio_data_in, ext_irq_a, ext_irq_b;
	logic comparator_select, wake_request;
	logic [32:0] q[$];
	int num_errors = 0, comparisons = 0;
	mpf_pkg::mpf_pin_in_t board = '1, pins;
	always #25 pclk = ~pclk;
	mpf_board_model mpf_board_model_i (.board, .bit_oe(bit_port_pins_oe), .pins,
		.key_oe({key_port_b_pins_oe, key_port_a_pins_oe}), .irqp_oe(interrupt_shared_port_pins_oe),
		.ana_oe(analog_shared_port_pins_oe), .pp_out(push_pull_port_pins_out),
		.pp_oe(push_pull_port_pins_oe), .ser_out({serial_data_pin_out, serial_clk_pin_out}),
		.ser_oe({serial_data_pin_oe, serial_clk_pin_oe}), .rst_oe(reset_pin_oe));
	mpf_port_top mpf_port_top_i (.*, .bit_port_pins_in(pins.bits), .bit_port_pins_out(),
		.key_port_a_pins_in(pins.key_a), .key_port_a_pins_out(), .key_port_b_pins_in(pins.key_b),
		.key_port_b_pins_out(), .serial_shared_input_pins_in(pins.serial),
		.interrupt_shared_port_pins_in(pins.irqp), .interrupt_shared_port_pins_out(),
		.analog_shared_port_pins_in(pins.analog), .analog_shared_port_pins_out(),
		.push_pull_port_pins_in(pins.push_pull), .reset_pin_in(pins.rst), .reset_pin_out(),
		.drop_detector_enable_pin(pins.dde));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Starts just after a rising edge and ends after one idle cycle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] n);
		if (!w) q.push_back(n);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		check({31'h0, pslverr}, {31'h0, a > mpf_pkg::OFF_MASK || a[1:0] != 2'h0}, "pslverr");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, 33'h0); endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0, {1'b1, e}); endtask
	task automatic wt(input int n); repeat (n) @(posedge pclk); endtask
	function automatic logic [31:0] step(input logic [31:0] s);
		for (int i = 0; i < 8; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && q.size() > 0) begin
			if (q[0][32]) check(prdata, q[0][31:0], "prdata");
			q.pop_front();
		end
	end
	initial begin
		#1000000;
		num_errors++;
		stop_test();
	end
	initial begin
		mpf_pkg::mpf_pin_in_t b;
		logic [31:0] d;
		wt(5);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) rd(8'(4 * i), i < 2 ? 32'hff : i < 4 ? 32'hf : 32'h0);
		wr(8'h3c, 32'hffffffff);
		rd(8'h3c, 32'h0);
		$display("test reset values done");
		for (int k = 0; k < 6; k++) begin
			lfsr = step(lfsr);
			b = {1'b1, lfsr};
			board <= b;
			d = step(lfsr);
			lfsr = d;
			wr(mpf_pkg::OFF_BIT_OUT, {24'h0, d[7:0]});
			wr(mpf_pkg::OFF_KEY_OUT, {24'h0, d[15:8]});
			wr(mpf_pkg::OFF_IRQP_OUT, {28'h0, d[19:16]});
			wr(mpf_pkg::OFF_ANA_OUT, {28'h0, d[23:20]});
			wr(mpf_pkg::OFF_PP_OUT, {28'h0, d[27:24]});
			wr(mpf_pkg::OFF_PP_DIR, {28'h0, d[31:28]});
			wr(mpf_pkg::OFF_PULL_EN, {24'h0, d[7:0]});
			wt(8);
			rd(mpf_pkg::OFF_PP_DIR, {28'h0, d[31:28]});
			rd(mpf_pkg::OFF_BIT_IN, {24'h0, b.bits & d[7:0]});
			rd(mpf_pkg::OFF_KEY_IN, {24'h0, {b.key_b, b.key_a} & d[15:8]});
			rd(mpf_pkg::OFF_MISC_IN, {24'h0, b.irqp & d[19:16], 1'b0, b.serial});
			rd(mpf_pkg::OFF_ANPP_IN, {24'h0, (d[27:24] & d[31:28]) | (b.push_pull & ~d[31:28]),
				b.analog & d[23:20]});
			check({timer2_count_in, timer4_count_in, sio_clk_in, sio_data_in, ext_irq_a, ext_irq_b,
				drop_detector_run, reset_pin_level}, {b.bits[6] & d[6], b.bits[7] & d[7], b.serial[0],
				b.serial[2], b.irqp[0] & d[16], b.irqp[1] & d[17], b.dde, 1'b1}, "alt inputs");
		end
		$display("test pins and latches done");
		b = '1;
		b.irqp = 4'h0;
		board <= b;
		wr(mpf_pkg::OFF_IRQP_OUT, 32'hf);
		wr(mpf_pkg::OFF_KEY_OUT, 32'hff);
		wt(8);
		apb(1'b0, mpf_pkg::OFF_STATUS, 32'h0, 33'h0);
		wr(mpf_pkg::OFF_MASK, 32'h1);
		b.irqp = 4'h1;
		board <= b;
		ram_backup <= 1'b1;
		wt(8);
		check({31'h0, irq}, 32'h1, "irq");
		rd(mpf_pkg::OFF_STATUS, 32'h1);
		wt(2);
		check({31'h0, irq}, 32'h0, "irq cleared");
		b.irqp = 4'h3;
		board <= b;
		wt(8);
		ram_backup <= 1'b0;
		check({31'h0, irq}, 32'h0, "irq masked");
		rd(mpf_pkg::OFF_STATUS, 32'h2);
		wr(mpf_pkg::OFF_MASK, 32'h4);
		wr(mpf_pkg::OFF_WAKE_EN, 32'h1);
		b.key_a = 4'he;
		board <= b;
		wt(8);
		check({31'h0, irq}, 32'h1, "key irq");
		rd(mpf_pkg::OFF_STATUS, 32'h4);
		wr(mpf_pkg::OFF_WAKE_EN, 32'h0);
		apb(1'b0, mpf_pkg::OFF_STATUS, 32'h0, 33'h0);
		rd(mpf_pkg::OFF_STATUS, 32'h0);
		$display("test interrupts done");
		board <= '1;
		wr(mpf_pkg::OFF_BIT_OUT, 32'hff);
		wr(mpf_pkg::OFF_FUNC, 32'h3);
		wt(2);
		check({30'h0, bit_port_pins_oe[7:6]}, 32'h3, "toggle start");
		for (int j = 0; j < 2; j++) begin
			timer1_underflow <= (j == 0);
			timer3_underflow <= (j == 1);
			wt(1);
			timer1_underflow <= 1'b0;
			timer3_underflow <= 1'b0;
			wt(3);
			check({30'h0, bit_port_pins_oe[7:6]}, j ? 32'h0 : 32'h2, "toggle");
		end
		for (int j = 0; j < 2; j++) begin
			wdt_reset_req <= (j == 0);
			vdd_reset_req <= (j == 1);
			wt(3);
			check({31'h0, reset_pin_oe}, 32'h1, "reset pin");
			wdt_reset_req <= 1'b0;
			vdd_reset_req <= 1'b0;
			wt(3);
		end
		wr(mpf_pkg::OFF_FUNC, 32'h1c);
		sio_clk_out <= 1'b1;
		wt(3);
		check({27'h0, comparator_select, serial_clk_pin_oe, serial_clk_pin_out, serial_data_pin_oe,
			serial_data_pin_out}, 32'h1e, "serial and comparator");
		$display("test alternate functions done");
		presetn <= 1'b0;
		wt(2);
		presetn <= 1'b1;
		rd(mpf_pkg::OFF_PP_DIR, 32'h0);
		rd(mpf_pkg::OFF_BIT_OUT, 32'hff);
		$display("test second reset done");
		stop_test();
	end
endmodule
bind mpf_port_top mpf_port_assertions mpf_port_assertions_i (.*);
